// >>> hdl/sac_conv_ctrl.sv
// successive-approximation sequencer with tri-state result outputs
`timescale 1ns/10ps
`default_nettype none
module sac_conv_ctrl
  import sac_pkg::*;
#(
  parameter int TRIAL_DIV = SAC_TRIAL_DIV
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic convertStart,
  input wire logic read_enable_n,
  input wire logic bipolarOpen,
  input wire logic compSumHigh,
  output logic [7:0] dacCode,
  output logic bipolarOffsetOn,
  output logic done_flag_n,
  output logic [7:0] dataOut,
  output logic [7:0] dataOe_n
);
  typedef struct packed
  {
    sac_state_type state;
    logic startDly;
    logic [7:0] sar;
    logic [7:0] trialMask;
    logic doneN;
    logic [7:0] dataOut;
    logic readEn;
  } sac_ctrl_type;

  sac_ctrl_type cur;
  sac_ctrl_type next_cur;
  logic tick;
  logic startRise;
  logic startFall;

  // ----------------------------------------
  // trial pacing
  // ----------------------------------------
  // the divider runs free, so the first strobe after the falling edge may land up to
  // one trial period late; the conversion time bound absorbs that jitter
  sac_trial_pacer #(.DIVIDE(TRIAL_DIV)) pacer
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(tick)
  );

  // ----------------------------------------
  // start edges
  // ----------------------------------------
  // the start pin is taken as synchronous, so one delay register yields both edges
  assign startRise = convertStart && !cur.startDly;
  assign startFall = !convertStart && cur.startDly;

  // ----------------------------------------
  // trial resolution
  // ----------------------------------------
  // a high comparator drops the bit under trial; shared by every trial step
  function automatic logic [7:0] sac_resolve(input logic [7:0] code,
    input logic [7:0] mask, input logic high);
    sac_resolve = high ? (code & ~mask) : code;
  endfunction

  always_comb
  begin
    next_cur = cur;
    next_cur.startDly = convertStart;
    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    if (startRise)
    begin
      // rising edge: reset logic, drop old result, raise flag
      next_cur.state = SAC_CLEAR;
      next_cur.sar = SAC_RESULT_RESET;
      next_cur.trialMask = 8'h00;
      next_cur.doneN = 1'b1;
    end
    else
    begin
      case (cur.state)
        SAC_IDLE:
          next_cur.state = SAC_IDLE;
        SAC_CLEAR:
          if (startFall)
          begin
            // trials wait for the falling edge only
            next_cur.state = SAC_TRIAL;
            next_cur.trialMask = 8'h80;
            next_cur.sar = 8'h80;
          end
        SAC_TRIAL:
          if (tick)
          begin
            // comparator judged the trial bit: drop it if sum exceeds input
            next_cur.sar = sac_resolve(cur.sar, cur.trialMask, compSumHigh);
            if (cur.trialMask == 8'h01)
            begin
              next_cur.state = SAC_DONE;
              next_cur.trialMask = 8'h00;
              next_cur.doneN = 1'b0;
            end
            else
            begin
              next_cur.trialMask = cur.trialMask >> 1;
              // the next bit is set in the same step in which this one resolves
              next_cur.sar = sac_resolve(cur.sar, cur.trialMask, compSumHigh)
                | (cur.trialMask >> 1);
            end
          end
        SAC_DONE:
          next_cur.state = SAC_DONE;
        default:
          next_cur.state = SAC_IDLE;
      endcase
    end
    // ----------------------------------------
    // output buffers: show the register, partial or final
    // ----------------------------------------
    next_cur.readEn = !read_enable_n;
    next_cur.dataOut = next_cur.sar;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cur <= '0;
      cur.state <= SAC_IDLE;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // coding is done by the analog offset switch; digital code stays straight
  assign bipolarOffsetOn = bipolarOpen;
  assign dacCode = cur.sar;
  assign done_flag_n = cur.doneN;
  assign dataOut = cur.dataOut;
  // enables follow read enable one clock late, so the host sees data a cycle after asking
  genvar gi;
  generate
    for (gi = 0; gi < SAC_BITS; gi = gi + 1)
    begin : oeBit
      assign dataOe_n[gi] = !cur.readEn;
    end
  endgenerate

  // ----------------------------------------
  // checks
  // ----------------------------------------
  flag_rise_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    startRise |-> ##[1:30] done_flag_n)
    else $error("completion flag not raised after start");
  flag_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cur.state == SAC_TRIAL) |-> done_flag_n)
    else $error("completion flag low during trials");
  restart_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cur.state == SAC_TRIAL && startRise) |=> cur.state == SAC_CLEAR && done_flag_n)
    else $error("start during trials did not restart");
  result_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    startRise |=> dacCode == 8'h00)
    else $error("old result not cleared");
  no_trial_early_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cur.state == SAC_CLEAR && !startFall && !startRise) |=> cur.state == SAC_CLEAR)
    else $error("trials began before falling edge");
  idle_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cur.state == SAC_IDLE && !startRise) |=> cur.state == SAC_IDLE && !done_flag_n)
    else $error("sequencer left idle without a start");
  msb_first_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cur.state == SAC_CLEAR && startFall && !startRise) |=> cur.trialMask == 8'h80)
    else $error("first trial not the top bit");
  mask_onehot_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cur.state == SAC_TRIAL) |-> $onehot(cur.trialMask))
    else $error("more than one bit under trial");
  bit_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cur.state == SAC_TRIAL && tick && compSumHigh && !startRise)
      |=> (dacCode & $past(cur.trialMask)) == 8'h00)
    else $error("trial bit kept despite high sum");
  bit_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cur.state == SAC_TRIAL && tick && !compSumHigh && !startRise)
      |=> (dacCode & $past(cur.trialMask)) == $past(cur.trialMask))
    else $error("trial bit dropped despite low sum");
  bit_pace_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cur.state == SAC_TRIAL && !tick && !startRise) |=> $stable(dacCode))
    else $error("register moved between trial strobes");
  done_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cur.state == SAC_TRIAL && tick && cur.trialMask == 8'h01 && !startRise)
      |=> !done_flag_n && cur.state == SAC_DONE)
    else $error("flag not low after last bit");
  done_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cur.state == SAC_DONE && !startRise) |=> !done_flag_n && $stable(dacCode))
    else $error("result or flag changed after completion");
  drive_enable_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ##1 (dataOe_n == {8{$past(read_enable_n)}}))
    else $error("output enable does not follow read enable");
  oe_uniform_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dataOe_n == 8'h00 || dataOe_n == 8'hFF)
    else $error("output enables split across bits");
  data_view_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dataOut == dacCode)
    else $error("outputs do not show register contents");
  mode_pass_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bipolarOffsetOn == bipolarOpen)
    else $error("offset switch does not follow mode");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  conv_done_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    cur.state == SAC_TRIAL ##[1:400] !done_flag_n);
  restart_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    cur.state == SAC_TRIAL ##1 startRise);
  early_read_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    cur.state == SAC_TRIAL && !read_enable_n);
  trial_start_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    cur.state == SAC_CLEAR && startFall);
  bipolar_read_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    bipolarOffsetOn && cur.state == SAC_DONE && !read_enable_n);
endmodule
`default_nettype wire

// >>> hdl/sac_pkg.sv
// constants and types of the successive-approximation conversion control
// Function
// - After the start rising edge the sequencer is reset and the completion flag goes high within the bound.
// - Bit trials begin only on the falling edge of the start pulse.
// - The register tests all eight bits in order from most to least significant.
// - Each trial bit is set, the comparator sampled, and the bit cleared if the weighted sum exceeds the input.
// - After the last bit the completion flag is driven low with the result held.
// - While read enable is low the eight result bits are driven, otherwise the outputs float; the enables here follow read enable one clock late.
// - In bipolar mode the codes run from all zeros through the top bit alone to all ones.
// - The start rising edge clears the previously held result.
// - Read enable during a conversion shows partial register contents.
package sac_pkg;
  // ----------------------------------------
  // widths and timing
  // ----------------------------------------
  localparam int SAC_BITS = 8;
  localparam int SAC_CLK_NS = 50;
  localparam int SAC_START_MIN_NS = 500;
  localparam int SAC_START_MIN_CYC = (SAC_START_MIN_NS + SAC_CLK_NS - 1) / SAC_CLK_NS;
  localparam int SAC_FLAG_MAX_NS = 1500;
  localparam int SAC_FLAG_MAX_CYC = SAC_FLAG_MAX_NS / SAC_CLK_NS;
  localparam int SAC_TRIAL_DIV = 40;
  localparam logic [7:0] SAC_RESULT_RESET = 8'h00;
  localparam logic [7:0] SAC_DIV_WIDTH_ONE = 8'h01;

  typedef enum logic [1:0] {SAC_IDLE, SAC_CLEAR, SAC_TRIAL, SAC_DONE} sac_state_type;
endpackage

// >>> hdl/sac_trial_pacer.sv
// free-running divider that yields one-cycle trial strobes
`timescale 1ns/10ps
`default_nettype none
module sac_trial_pacer
  import sac_pkg::*;
#(
  parameter int DIVIDE = SAC_TRIAL_DIV
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic tick
);
  typedef struct packed
  {
    logic [7:0] count;
    logic tick;
  } sac_pacer_type;

  sac_pacer_type cur;
  sac_pacer_type next_cur;

  always_comb
  begin
    next_cur = cur;
    next_cur.tick = 1'b0;
    // ----------------------------------------
    // one strobe every DIVIDE cycles
    // ----------------------------------------
    if (cur.count == 8'(DIVIDE - 1))
    begin
      next_cur.count = 8'h00;
      next_cur.tick = 1'b1;
    end
    else
    begin
      next_cur.count = cur.count + SAC_DIV_WIDTH_ONE;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign tick = cur.tick;

  tick_spacing_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick |=> !tick)
    else $error("trial strobe lasted more than one cycle");
endmodule
`default_nettype wire

// >>> testbench/sac_analog_model.sv
// comparator model standing in for the analog input stage
`timescale 1ns/10ps
`default_nettype none
module sac_analog_model
(
  input wire logic [7:0] vinLevel,
  input wire logic [7:0] dacCode,
  input wire logic bipolarOffsetOn,
  output logic compSumHigh
);
  logic [7:0] effLevel;
  // offset current lifts a signed input by half scale
  assign effLevel = bipolarOffsetOn ? (vinLevel ^ 8'h80) : vinLevel;
  assign compSumHigh = (dacCode > effLevel);
endmodule
`default_nettype wire

// >>> testbench/sar_adc_conversion_control_tb.sv
// self-checking bench of the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module sar_adc_conversion_control_tb
  import sac_pkg::*;
;
  typedef struct {logic bip; logic [7:0] vin; logic [7:0] code;} sac_row_type;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic convertStart = 1'b0;
  logic read_enable_n = 1'b1;
  logic bipolarOpen = 1'b0;
  logic [7:0] vinLevel = 8'h00;
  logic compSumHigh;
  logic [7:0] dacCode;
  logic bipolarOffsetOn;
  logic done_flag_n;
  logic [7:0] dataOut;
  logic [7:0] dataOe_n;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  sac_row_type rows [7] = '{'{1'b0, 8'h00, 8'h00}, '{1'b0, 8'hFF, 8'hFF}, '{1'b0, 8'h5A, 8'h5A},
    '{1'b1, 8'h80, 8'h00}, '{1'b1, 8'h00, 8'h80}, '{1'b1, 8'h7F, 8'hFF}, '{1'b1, 8'hFE, 8'h7E}};
  localparam int TB_TRIAL_DIV = 2;
  // short trial period keeps each conversion to a few dozen cycles
  sac_conv_ctrl #(.TRIAL_DIV(TB_TRIAL_DIV)) sac_conv_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .convertStart(convertStart), .read_enable_n(read_enable_n), .bipolarOpen(bipolarOpen),
    .compSumHigh(compSumHigh), .dacCode(dacCode), .bipolarOffsetOn(bipolarOffsetOn),
    .done_flag_n(done_flag_n), .dataOut(dataOut), .dataOe_n(dataOe_n));
  sac_analog_model sac_analog_model_inst (.vinLevel(vinLevel), .dacCode(dacCode),
    .bipolarOffsetOn(bipolarOffsetOn), .compSumHigh(compSumHigh));
  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic conclude();
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // sample a little after the edge so that its updates have landed
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic convert(input logic [7:0] exp);
    int k;
    @(posedge clk_sys) convertStart <= 1'b1;
    repeat (SAC_START_MIN_CYC) tick();
    chk("doneHigh", {7'h00, done_flag_n}, 8'h01);
    chk("noTrialOnRise", dacCode, 8'h00);
    @(posedge clk_sys) convertStart <= 1'b0;
    k = 0;
    do
    begin
      tick();
      k++;
    end while (done_flag_n !== 1'b0 && k < 200);
    // eight trial periods; the free divider adds at most one cycle of phase
    chk("trialCount", {7'h00, k >= SAC_BITS * TB_TRIAL_DIV && k <= SAC_BITS * TB_TRIAL_DIV + 1},
      8'h01);
    chk("result", dacCode, exp);
  endtask
  task automatic readOut(input logic [7:0] exp);
    @(posedge clk_sys) read_enable_n <= 1'b0;
    tick();
    tick();
    chk("oeOn", dataOe_n, 8'h00);
    chk("data", dataOut, exp);
    @(posedge clk_sys) read_enable_n <= 1'b1;
    tick();
    tick();
    chk("oeOff", dataOe_n, 8'hFF);
  endtask
  initial
  begin
    repeat (20) tick();
    chk("rstDone", {7'h00, done_flag_n}, 8'h00);
    chk("rstOe", dataOe_n, 8'hFF);
    @(posedge clk_sys) rst_n <= 1'b1;
    foreach (rows[i])
    begin
      @(posedge clk_sys)
      begin
        bipolarOpen <= rows[i].bip;
        vinLevel <= rows[i].vin;
      end
      tick();
      chk("offsetSw", {7'h00, bipolarOffsetOn}, {7'h00, rows[i].bip});
      convert(rows[i].code);
      readOut(rows[i].code);
    end
    // read during a conversion, then restart mid-trial
    @(posedge clk_sys) convertStart <= 1'b1;
    repeat (SAC_START_MIN_CYC) tick();
    @(posedge clk_sys) convertStart <= 1'b0;
    repeat (4) tick();
    @(posedge clk_sys) read_enable_n <= 1'b0;
    tick();
    tick();
    chk("partialOe", dataOe_n, 8'h00);
    // three strobes have passed: top three bits of 7E resolved, bit 4 under trial
    chk("partial", dataOut, 8'h70);
    chk("partialCode", dacCode, 8'h70);
    chk("stillBusy", {7'h00, done_flag_n}, 8'h01);
    @(posedge clk_sys) read_enable_n <= 1'b1;
    @(posedge clk_sys) convertStart <= 1'b1;
    tick();
    tick();
    chk("restartClr", dacCode, 8'h00);
    convert(8'h7E);
    // reset in the middle of the trials, then release and convert again
    @(posedge clk_sys) convertStart <= 1'b1;
    repeat (SAC_START_MIN_CYC) tick();
    @(posedge clk_sys) convertStart <= 1'b0;
    repeat (4) tick();
    @(posedge clk_sys) rst_n <= 1'b0;
    tick();
    tick();
    chk("midRstCode", dacCode, 8'h00);
    chk("midRstDone", {7'h00, done_flag_n}, 8'h00);
    @(posedge clk_sys) rst_n <= 1'b1;
    tick();
    tick();
    chk("relIdleCode", dacCode, 8'h00);
    chk("relIdleDone", {7'h00, done_flag_n}, 8'h00);
    convert(8'h7E);
    readOut(8'h7E);
    conclude();
  end
endmodule
`default_nettype wire
